// ===== hdl/rtc_regs.vh
/*
  Register offsets, field positions, reset values and timing figures of the
  calendar clock block. Assumes it is included by bare name into the design
  files that need it.
*/
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define RTC_OFS_CTRL 8'h00
`define RTC_OFS_TIME 8'h04
`define RTC_OFS_DAY 8'h08
`define RTC_OFS_ALM0_TIME 8'h0C
`define RTC_OFS_ALM1_TIME 8'h10
`define RTC_OFS_ALM1_DAY 8'h14
`define RTC_OFS_SWATCH 8'h18
`define RTC_OFS_STAT 8'h1C
`define RTC_OFS_MASK 8'h20

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define RTC_CTRL_ALM0_EN 0
`define RTC_CTRL_ALM1_EN 1
`define RTC_CTRL_SW_EN 2
`define RTC_CTRL_PER_LSB 4
`define RTC_CTRL_PER_MSB 7
`define RTC_CTRL_RST 32'h0000_0000

// ------------------------------------------------------------
// Time word fields
// ------------------------------------------------------------
`define RTC_SEC_LSB 0
`define RTC_SEC_MSB 5
`define RTC_MIN_LSB 8
`define RTC_MIN_MSB 13
`define RTC_HOUR_LSB 16
`define RTC_HOUR_MSB 20
`define RTC_SEC_LAST 6'h3B
`define RTC_MIN_LAST 6'h3B
`define RTC_HOUR_LAST 5'h17
`define RTC_DAY_W 15

// ------------------------------------------------------------
// Status and mask bits (same layout)
// ------------------------------------------------------------
`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALM0 4
`define RTC_EV_ALM1 5
`define RTC_EV_SW 6
`define RTC_EV_N 7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RTC_LF_HZ 32768
`define RTC_TICK_HZ 1
`define RTC_PRESCALE_DIV (`RTC_LF_HZ / `RTC_TICK_HZ)

`endif

// ===== hdl/rtc_prescale.v
/*
  Samples the low-frequency timebase pin, finds its rising edges and divides
  them down to a one-cycle seconds tick in the system clock.
  Assumes the system clock runs well above twice the timebase rate.
*/
`timescale 1ns/10ps

module rtc_prescale
#(
  parameter DIV = 32768,
  parameter CW = 16
)
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Timebase and tick
  input wire i_lf_clk,
  output reg o_tick
);

  localparam integer LAST_I = DIV - 1;
  localparam [CW-1:0] LAST = LAST_I[CW-1:0];

  // ------------------------------------------------------------
  // Synchroniser and edge detector
  // ------------------------------------------------------------
  reg lf_s1;
  reg lf_s2;
  reg lf_s3;
  reg [CW-1:0] cnt;
  wire lf_rise;

  // The first stage feeds only the second; the edge is taken further down.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      lf_s1 <= 1'b0;
      lf_s2 <= 1'b0;
      lf_s3 <= 1'b0;
    end
    else
    begin
      lf_s1 <= i_lf_clk;
      lf_s2 <= lf_s1;
      lf_s3 <= lf_s2;
    end
  end

  assign lf_rise = lf_s2 & ~lf_s3;

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      cnt <= {CW{1'b0}};
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (lf_rise)
      begin
        if (cnt == LAST)
        begin
          cnt <= {CW{1'b0}};
          o_tick <= 1'b1;
        end
        else
        begin
          cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // rtc_prescale

// ===== hdl/rtc_core.v
/*
  Calendar clock with two alarms, a countdown stopwatch, periodic events,
  sticky status with mask, an interrupt and a wakeup pulse, reached over a
  plain register port with read data one cycle after the strobe.
  Assumes the timebase pin is a free-running low-frequency clock and that
  the system clock is kept running while timekeeping must go on.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
// Operation
// - Prescale timebase down to one-second tick.
// - Seconds wrap after sixty, carry into minutes.
// - Minutes wrap sixty, hours wrap twenty-four.
// - Day counter with 32768 values.
// - Enabled alarm interrupts when time equals setting.
// - First alarm matches time of day daily.
// - Second alarm matches day plus time.
// - Stopwatch loaded by software, counts down per second.
// - Enabled stopwatch underflow raises an interrupt.
// - Selectable second, minute, hour, day periodic events.
// - Any enabled event produces a wakeup indication.
// - Timekeeping keeps counting independent of sleep.
`timescale 1ns/10ps
`include "rtc_regs.vh"

module rtc_core
#(
  parameter PRESCALE_DIV = `RTC_PRESCALE_DIV,
  parameter PRESCALE_W = 16,
  parameter SW_W = 16
)
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Low-frequency timebase
  input wire i_lf_clk,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Events
  output reg o_irq,
  output reg o_wakeup
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  wire tick;
  reg [31:0] ctrl;
  reg [5:0] sec;
  reg [5:0] min;
  reg [4:0] hour;
  reg [`RTC_DAY_W-1:0] day;
  reg [5:0] a0_sec;
  reg [5:0] a0_min;
  reg [4:0] a0_hour;
  reg [5:0] a1_sec;
  reg [5:0] a1_min;
  reg [4:0] a1_hour;
  reg [`RTC_DAY_W-1:0] a1_day;
  reg [SW_W-1:0] sw_cnt;
  reg [`RTC_EV_N-1:0] stat;
  reg [`RTC_EV_N-1:0] mask;
  reg cmp_pend;
  reg [`RTC_EV_N-1:0] ev;
  reg [31:0] next_rdata;

  wire wr_ctrl = i_wr && (i_addr == `RTC_OFS_CTRL);
  wire wr_time = i_wr && (i_addr == `RTC_OFS_TIME);
  wire wr_day = i_wr && (i_addr == `RTC_OFS_DAY);
  wire wr_a0 = i_wr && (i_addr == `RTC_OFS_ALM0_TIME);
  wire wr_a1t = i_wr && (i_addr == `RTC_OFS_ALM1_TIME);
  wire wr_a1d = i_wr && (i_addr == `RTC_OFS_ALM1_DAY);
  wire wr_sw = i_wr && (i_addr == `RTC_OFS_SWATCH);
  wire wr_stat = i_wr && (i_addr == `RTC_OFS_STAT);
  wire wr_mask = i_wr && (i_addr == `RTC_OFS_MASK);

  // ------------------------------------------------------------
  // Seconds tick
  // ------------------------------------------------------------
  // The timebase is brought into the system clock here, so every event
  // below is already a system-clock pulse.
  rtc_prescale #(
    .DIV(PRESCALE_DIV),
    .CW(PRESCALE_W)
  ) u_prescale (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_lf_clk(i_lf_clk),
    .o_tick(tick)
  );

  // ------------------------------------------------------------
  // Time-of-day and day counters
  // ------------------------------------------------------------
  wire sec_wrap = tick && (sec == `RTC_SEC_LAST);
  wire min_wrap = sec_wrap && (min == `RTC_MIN_LAST);
  wire hour_wrap = min_wrap && (hour == `RTC_HOUR_LAST);

  // There is no sleep input: nothing here stops counting while the rest of
  // the system is idle, only reset does.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      sec <= 6'h00;
      min <= 6'h00;
      hour <= 5'h00;
      day <= {`RTC_DAY_W{1'b0}};
    end
    else
    begin
      // A software write to the time word wins over a tick in that cycle.
      if (wr_time)
      begin
        sec <= i_wdata[`RTC_SEC_MSB:`RTC_SEC_LSB];
        min <= i_wdata[`RTC_MIN_MSB:`RTC_MIN_LSB];
        hour <= i_wdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB];
      end
      else if (tick)
      begin
        sec <= sec_wrap ? 6'h00 : sec + 6'h01;
        if (sec_wrap)
        begin
          min <= min_wrap ? 6'h00 : min + 6'h01;
        end
        if (min_wrap)
        begin
          hour <= hour_wrap ? 5'h00 : hour + 5'h01;
        end
      end
      if (wr_day)
      begin
        day <= i_wdata[`RTC_DAY_W-1:0];
      end
      else if (hour_wrap)
      begin
        day <= day + {{(`RTC_DAY_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ctrl <= `RTC_CTRL_RST;
      mask <= {`RTC_EV_N{1'b0}};
      a0_sec <= 6'h00;
      a0_min <= 6'h00;
      a0_hour <= 5'h00;
      a1_sec <= 6'h00;
      a1_min <= 6'h00;
      a1_hour <= 5'h00;
      a1_day <= {`RTC_DAY_W{1'b0}};
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl <= i_wdata;
      end
      if (wr_mask)
      begin
        mask <= i_wdata[`RTC_EV_N-1:0];
      end
      if (wr_a0)
      begin
        a0_sec <= i_wdata[`RTC_SEC_MSB:`RTC_SEC_LSB];
        a0_min <= i_wdata[`RTC_MIN_MSB:`RTC_MIN_LSB];
        a0_hour <= i_wdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB];
      end
      if (wr_a1t)
      begin
        a1_sec <= i_wdata[`RTC_SEC_MSB:`RTC_SEC_LSB];
        a1_min <= i_wdata[`RTC_MIN_MSB:`RTC_MIN_LSB];
        a1_hour <= i_wdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB];
      end
      if (wr_a1d)
      begin
        a1_day <= i_wdata[`RTC_DAY_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Stopwatch
  // ------------------------------------------------------------
  // On underflow the count wraps to all ones and keeps running, so a
  // stopwatch left enabled interrupts again one full period later.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      sw_cnt <= {SW_W{1'b0}};
    end
    else if (wr_sw)
    begin
      sw_cnt <= i_wdata[SW_W-1:0];
    end
    else if (tick && ctrl[`RTC_CTRL_SW_EN])
    begin
      sw_cnt <= sw_cnt - {{(SW_W-1){1'b0}}, 1'b1};
    end
  end

  // ------------------------------------------------------------
  // Alarm comparison
  // ------------------------------------------------------------
  // Compare one cycle after the tick, once the counters hold the new time,
  // so each match fires exactly once per matching second.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      cmp_pend <= 1'b0;
    end
    else
    begin
      cmp_pend <= tick;
    end
  end

  wire tod_eq0 = (sec == a0_sec) && (min == a0_min) && (hour == a0_hour);
  wire tod_eq1 = (sec == a1_sec) && (min == a1_min) && (hour == a1_hour);

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  always @*
  begin
    ev = {`RTC_EV_N{1'b0}};
    ev[`RTC_EV_SEC] = tick && ctrl[`RTC_CTRL_PER_LSB];
    ev[`RTC_EV_MIN] = sec_wrap && ctrl[`RTC_CTRL_PER_LSB+1];
    ev[`RTC_EV_HOUR] = min_wrap && ctrl[`RTC_CTRL_PER_LSB+2];
    ev[`RTC_EV_DAY] = hour_wrap && ctrl[`RTC_CTRL_PER_MSB];
    ev[`RTC_EV_ALM0] = cmp_pend && ctrl[`RTC_CTRL_ALM0_EN] && tod_eq0;
    ev[`RTC_EV_ALM1] = cmp_pend && ctrl[`RTC_CTRL_ALM1_EN] && tod_eq1 && (day == a1_day);
    ev[`RTC_EV_SW] = tick && ctrl[`RTC_CTRL_SW_EN] && (sw_cnt == {SW_W{1'b0}});
  end

  // ------------------------------------------------------------
  // Sticky status, write one to clear
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RTC_EV_N; gi = gi + 1)
    begin : g_stat
      // A new event in the clearing cycle keeps the bit set.
      always @(posedge i_clk_sys)
      begin
        if (i_sys_rst)
        begin
          stat[gi] <= 1'b0;
        end
        else
        begin
          stat[gi] <= ev[gi] | (stat[gi] & ~(wr_stat & i_wdata[gi]));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Interrupt and wakeup outputs
  // ------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_irq <= 1'b0;
      o_wakeup <= 1'b0;
    end
    else
    begin
      o_irq <= |(stat & mask);
      o_wakeup <= |(ev & mask);
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      `RTC_OFS_CTRL: next_rdata = ctrl;
      `RTC_OFS_TIME:
      begin
        next_rdata[`RTC_SEC_MSB:`RTC_SEC_LSB] = sec;
        next_rdata[`RTC_MIN_MSB:`RTC_MIN_LSB] = min;
        next_rdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB] = hour;
      end
      `RTC_OFS_DAY: next_rdata[`RTC_DAY_W-1:0] = day;
      `RTC_OFS_ALM0_TIME:
      begin
        next_rdata[`RTC_SEC_MSB:`RTC_SEC_LSB] = a0_sec;
        next_rdata[`RTC_MIN_MSB:`RTC_MIN_LSB] = a0_min;
        next_rdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB] = a0_hour;
      end
      `RTC_OFS_ALM1_TIME:
      begin
        next_rdata[`RTC_SEC_MSB:`RTC_SEC_LSB] = a1_sec;
        next_rdata[`RTC_MIN_MSB:`RTC_MIN_LSB] = a1_min;
        next_rdata[`RTC_HOUR_MSB:`RTC_HOUR_LSB] = a1_hour;
      end
      `RTC_OFS_ALM1_DAY: next_rdata[`RTC_DAY_W-1:0] = a1_day;
      `RTC_OFS_SWATCH: next_rdata[SW_W-1:0] = sw_cnt;
      `RTC_OFS_STAT: next_rdata[`RTC_EV_N-1:0] = stat;
      `RTC_OFS_MASK: next_rdata[`RTC_EV_N-1:0] = mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end
  end

endmodule // rtc_core

// ===== test/rtc_core_properties.sv
/*
  Port-level assertions for the calendar clock core, bound to rtc_core.
  Assumes the register port is driven as single strobes with no overlap.
*/
`timescale 1ns/10ps
`include "rtc_regs.vh"

module rtc_core_properties
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Timebase
  input wire i_lf_clk,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  // Events
  input wire o_irq,
  input wire o_wakeup
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // A copy of the mask lets the interrupt be judged without internal access.
  reg [6:0] mask_copy;
  wire clr_wr;
  assign clr_wr = i_wr && (i_addr == `RTC_OFS_STAT || i_addr == `RTC_OFS_MASK);
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      mask_copy <= 7'h00;
    else if (i_wr && i_addr == `RTC_OFS_MASK)
      mask_copy <= i_wdata[6:0];
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero:
    assert property ($past(i_rd) && $past(i_addr) > `RTC_OFS_MASK |-> o_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_reset_quiet:
    assert property (disable iff (1'b0) i_sys_rst
      |=> o_rdata == 32'h0000_0000 && !o_irq && !o_wakeup)
    else $error("outputs active during reset");
  a_ctrl_readback:
    assert property ((i_wr && i_addr == `RTC_OFS_CTRL) ##2 (i_rd && i_addr == `RTC_OFS_CTRL)
      |=> o_rdata == $past(i_wdata, 3))
    else $error("control word did not read back");
  a_mask_readback:
    assert property (i_rd && i_addr == `RTC_OFS_MASK
      |=> o_rdata == {25'h000_0000, $past(mask_copy)})
    else $error("mask did not read back");
  a_mask_quiet:
    assert property ($past(mask_copy, 2) == 7'h00 && $past(mask_copy) == 7'h00
      |-> !o_irq && !o_wakeup)
    else $error("event signalled with all mask bits clear");
  a_wake_irq:
    assert property (o_wakeup |-> ##[0:2] o_irq)
    else $error("wakeup without interrupt");
  a_irq_fall_cause:
    assert property ($fell(o_irq) |-> $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("interrupt dropped without a clear or mask write");
endmodule // rtc_core_properties

bind rtc_core rtc_core_properties chk_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_lf_clk(i_lf_clk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_wakeup(o_wakeup));

// ===== test/tb.sv
/*
  Self-checking bench for the calendar clock core.
  Assumes the timebase pin may stand still, so the bench pulses it by hand.
*/
`timescale 1ns/10ps
`include "rtc_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module tb;
  // A short prescale keeps each second to a few dozen cycles.
  localparam int DIV = 4;
  reg i_clk_sys = 1'b0;
  reg i_sys_rst = 1'b1;
  reg i_lf_clk = 1'b0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0000_0000;
  wire [31:0] o_rdata;
  wire o_irq;
  wire o_wakeup;
  int errors = 0;
  int n_checks = 0;
  int wakes = 0;
  reg [31:0] rv;

  rtc_core #(.PRESCALE_DIV(DIV)) dut_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_lf_clk(i_lf_clk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_wakeup(o_wakeup));

  initial
  begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
  begin
    if (o_wakeup === 1'b1)
      wakes++;
  end

  // ------------------------------------------------------------
  // Bus and timebase tasks
  // ------------------------------------------------------------
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic chk_reg(input [7:0] a, input [31:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    `CHK(rv, e)
  endtask

  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge i_clk_sys);
      i_lf_clk <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      i_lf_clk <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
    repeat (12) @(posedge i_clk_sys);
    #1;
  endtask

  function automatic [31:0] tw(input [4:0] h, input [5:0] m, input [5:0] s);
    tw = {11'h000, h, 2'h0, m, 2'h0, s};
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int k = 0; k < 9; k++)
      chk_reg(8'(k * 4), 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    chk_reg(8'h24, 32'h0000_0000);
  endtask

  task automatic t_roll;
    wr(`RTC_OFS_CTRL, 32'h0000_00F0);
    chk_reg(`RTC_OFS_CTRL, 32'h0000_00F0);
    wr(`RTC_OFS_TIME, tw(5'h17, 6'h3B, 6'h3A));
    wr(`RTC_OFS_DAY, 32'h0000_7FFF);
    pulses(DIV - 1);
    chk_reg(`RTC_OFS_TIME, tw(5'h17, 6'h3B, 6'h3A));
    pulses(1);
    chk_reg(`RTC_OFS_TIME, tw(5'h17, 6'h3B, 6'h3B));
    chk_reg(`RTC_OFS_STAT, 32'h0000_0001);
    wr(`RTC_OFS_STAT, 32'h0000_007F);
    pulses(DIV);
    chk_reg(`RTC_OFS_TIME, 32'h0000_0000);
    chk_reg(`RTC_OFS_DAY, 32'h0000_0000);
    chk_reg(`RTC_OFS_STAT, 32'h0000_000F);
    wr(`RTC_OFS_STAT, 32'h0000_007F);
    wr(`RTC_OFS_TIME, tw(5'h00, 6'h00, 6'h3B));
    pulses(DIV);
    chk_reg(`RTC_OFS_TIME, tw(5'h00, 6'h01, 6'h00));
    chk_reg(`RTC_OFS_STAT, 32'h0000_0003);
  endtask

  task automatic t_irq;
    wr(`RTC_OFS_CTRL, 32'h0000_0010);
    wr(`RTC_OFS_STAT, 32'h0000_007F);
    wr(`RTC_OFS_MASK, 32'h0000_0001);
    chk_reg(`RTC_OFS_MASK, 32'h0000_0001);
    wakes = 0;
    pulses(DIV);
    `CHK(o_irq, 1'b1)
    `CHK(wakes, 1)
    wr(`RTC_OFS_MASK, 32'h0000_0000);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0001);
    `CHK(o_irq, 1'b0)
    wr(`RTC_OFS_MASK, 32'h0000_0001);
    chk_reg(`RTC_OFS_MASK, 32'h0000_0001);
    `CHK(o_irq, 1'b1)
    wr(`RTC_OFS_STAT, 32'h0000_0001);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0000);
    `CHK(o_irq, 1'b0)
    wr(`RTC_OFS_MASK, 32'h0000_0000);
    pulses(DIV);
    `CHK(wakes, 1)
    `CHK(o_irq, 1'b0)
    chk_reg(`RTC_OFS_TIME, tw(5'h00, 6'h01, 6'h02));
  endtask

  task automatic t_alarm;
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    wr(`RTC_OFS_ALM0_TIME, tw(5'h0A, 6'h14, 6'h1F));
    wr(`RTC_OFS_DAY, 32'h0000_0005);
    wr(`RTC_OFS_TIME, tw(5'h0A, 6'h14, 6'h1E));
    wr(`RTC_OFS_STAT, 32'h0000_007F);
    pulses(DIV);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0010);
    wr(`RTC_OFS_STAT, 32'h0000_007F);
    wr(`RTC_OFS_CTRL, 32'h0000_0002);
    wr(`RTC_OFS_ALM1_TIME, tw(5'h0A, 6'h14, 6'h20));
    wr(`RTC_OFS_ALM1_DAY, 32'h0000_0006);
    pulses(DIV);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0000);
    wr(`RTC_OFS_TIME, tw(5'h0A, 6'h14, 6'h1F));
    wr(`RTC_OFS_DAY, 32'h0000_0006);
    pulses(DIV);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0020);
    wr(`RTC_OFS_STAT, 32'h0000_007F);
    wr(`RTC_OFS_TIME, tw(5'h0A, 6'h14, 6'h1E));
    pulses(DIV);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0000);
  endtask

  task automatic t_swatch;
    wr(`RTC_OFS_SWATCH, 32'h0000_0002);
    wr(`RTC_OFS_CTRL, 32'h0000_0004);
    pulses(DIV);
    chk_reg(`RTC_OFS_SWATCH, 32'h0000_0001);
    pulses(DIV);
    chk_reg(`RTC_OFS_SWATCH, 32'h0000_0000);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0000);
    pulses(DIV);
    chk_reg(`RTC_OFS_STAT, 32'h0000_0040);
    chk_reg(`RTC_OFS_SWATCH, 32'h0000_FFFF);
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    give_verdict;
  end

  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_reset;
    t_roll;
    t_irq;
    t_alarm;
    t_swatch;
    give_verdict;
  end
endmodule // tb
